// ==== pqt_pkg.sv ====
// constants, register map and carrier types of the pattern trigger qualifier
// assumes one 10 MHz sampling clock; times are held as counts of that clock
package pqt_pkg;
  localparam int NUM_CHAN = 4;
  localparam int CRIT_W = 3;
  localparam int SYM_COUNT = 6;
  // clock period and documented time limits, in picoseconds
  localparam longint CLK_PERIOD_PS = 100000;
  localparam longint TIME_LEAST_PS = 1500;
  localparam longint RANGE_MIN_LEAST_PS = 10000;
  localparam longint RANGE_MAX_LEAST_PS = 15000;
  localparam longint TIME_MOST_PS = 64'd10_000_000_000_000;
  // least times round up, longest time rounds down, never below one cycle
  localparam longint LEAST_RAW = (TIME_LEAST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint RMIN_RAW = (RANGE_MIN_LEAST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint RMAX_RAW = (RANGE_MAX_LEAST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [31:0] LEAST_CYCLES = 32'(LEAST_RAW < 1 ? 1 : LEAST_RAW);
  localparam logic [31:0] RANGE_MIN_CYCLES = 32'(RMIN_RAW < 1 ? 1 : RMIN_RAW);
  localparam logic [31:0] RANGE_MAX_CYCLES = 32'(RMAX_RAW < 1 ? 1 : RMAX_RAW);
  localparam logic [31:0] MOST_CYCLES = 32'(TIME_MOST_PS / CLK_PERIOD_PS);
  // register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CRIT = 6'h04;
  localparam logic [5:0] OFS_MIN_LIMIT = 6'h08;
  localparam logic [5:0] OFS_MAX_LIMIT = 6'h0C;
  localparam logic [5:0] OFS_SER_PATTERN = 6'h10;
  localparam logic [5:0] OFS_STATE = 6'h14;
  localparam logic [5:0] OFS_IRQ_STATUS = 6'h18;
  localparam logic [5:0] OFS_IRQ_CLEAR = 6'h1C;
  localparam logic [5:0] OFS_IRQ_ENABLE = 6'h20;
  // reset values
  localparam logic [31:0] RST_MIN_LIMIT = 32'h0000_0001;
  localparam logic [31:0] RST_MAX_LIMIT = 32'h0000_0002;
  localparam logic [11:0] RST_SER_PATTERN = 12'h001;
  // status bit positions
  localparam int IRQ_PAT = 0;
  localparam int IRQ_SER = 1;
  localparam int IRQ_W = 2;
  // per-channel criterion codes
  localparam logic [2:0] CRIT_IGNORE = 3'h0;
  localparam logic [2:0] CRIT_HIGH = 3'h1;
  localparam logic [2:0] CRIT_LOW = 3'h2;
  localparam logic [2:0] CRIT_RISE = 3'h3;
  localparam logic [2:0] CRIT_FALL = 3'h4;
  // serial pattern symbol codes
  localparam logic [1:0] SYM_PLUS = 2'h1;
  localparam logic [1:0] SYM_MINUS = 2'h3;

  typedef enum logic [2:0] {
    COND_ENTERED,
    COND_EXITED,
    duration_longer_than,
    duration_shorter_than,
    COND_RANGE
  } pqt_cond_t;

  typedef struct packed {
    logic [24:0] pad;
    logic [1:0] serial_pattern_input_select;
    logic serial_pattern_edge_sense;
    logic fire_on_match_end;
    pqt_cond_t cond;
  } pqt_ctrl_t;

  localparam pqt_ctrl_t RST_CTRL = '{pad: '0, serial_pattern_input_select: 2'h0,
    serial_pattern_edge_sense: 1'b1, fire_on_match_end: 1'b1, cond: COND_ENTERED};
endpackage

// ==== pqt_sync.sv ====
// two-stage synchroniser for a group of independent level inputs
// assumes inputs are asynchronous comparator levels; clock enable freezes both stages
module pqt_sync #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          meta[gi] <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else if (ce_in) begin
          meta[gi] <= async_in[gi];
          sync_out[gi] <= meta[gi];
        end
      end
    end
  endgenerate
endmodule

// ==== pqt_chan_eval.sv ====
// one channel's contribution to the pattern match
// assumes level and previous level are synchronised samples of one comparator
module pqt_chan_eval (
  input wire logic level_in,
  input wire logic level_prev_in,
  input wire logic [2:0] crit_in,
  output logic ok_out
);
  always_comb begin
    case (crit_in)
      pqt_pkg::CRIT_IGNORE: ok_out = 1'b1;
      pqt_pkg::CRIT_HIGH: ok_out = level_in;
      pqt_pkg::CRIT_LOW: ok_out = ~level_in;
      pqt_pkg::CRIT_RISE: ok_out = level_in & ~level_prev_in;
      pqt_pkg::CRIT_FALL: ok_out = ~level_in & level_prev_in;
      default: ok_out = 1'b1;
    endcase
  end
endmodule

// ==== pqt_qualifier.sv ====
// pattern trigger qualifier with serial-pattern edge trigger, Avalon-MM registers
// assumes comparator levels arrive asynchronously; software sets all limits in clock cycles
// Notes on behaviour
// - positive sense fires serial trigger on rising edge
// - negative sense fires it on falling edge
// - edge sense also gates serial pattern validity
// - edge sense reads back as one bit
// - serial trigger source is one selected channel
// - high above channel level, low below
// - match is AND over all channel criteria
// - ignored channels never affect the match
// - entered fires when match becomes true
// - exited fires when match becomes false
// - longer-than fires after match outlasts minimum limit
// - longer-than fires at match end or timeout
// - shorter-than fires when short match ends
// - range fires at end if duration inside limits
// - criteria: high, low, ignore, rising, falling
// - one shared comparator level per channel
module pqt_qualifier #(
  parameter logic [31:0] MOST_CYCLES = pqt_pkg::MOST_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [pqt_pkg::NUM_CHAN-1:0] chan_above_level_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic pattern_trigger_out,
  output logic serial_trigger_out,
  output logic irq_out
);
  localparam int N = pqt_pkg::NUM_CHAN;

  pqt_pkg::pqt_ctrl_t ctrl;
  logic [N*pqt_pkg::CRIT_W-1:0] crit;
  logic [31:0] min_duration_limit;
  logic [31:0] max_duration_limit;
  logic [2*pqt_pkg::SYM_COUNT-1:0] ser_pattern;
  logic [pqt_pkg::IRQ_W-1:0] irq_status;
  logic [pqt_pkg::IRQ_W-1:0] irq_enable;
  logic [N-1:0] lvl;
  logic [N-1:0] lvl_prev;
  logic match_prev;
  logic [31:0] dur_cnt;

  // comparator levels, one per channel, shared by every trigger type
  pqt_sync #(.WIDTH(N)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in(chan_above_level_in),
    .sync_out(lvl)
  );

  // pattern match over all channels
  wire [N-1:0] chan_ok;
  genvar gc;
  generate
    for (gc = 0; gc < N; gc++) begin : g_chan
      pqt_chan_eval u_eval (
        .level_in(lvl[gc]),
        .level_prev_in(lvl_prev[gc]),
        .crit_in(crit[gc*pqt_pkg::CRIT_W +: pqt_pkg::CRIT_W]),
        .ok_out(chan_ok[gc])
      );
    end
  endgenerate
  wire match_now = &chan_ok;
  wire match_rise = match_now & ~match_prev;
  wire match_fall = ~match_now & match_prev;

  // limits clamped to the settable span
  wire [31:0] lim_least = (ctrl.cond == pqt_pkg::COND_RANGE) ? pqt_pkg::RANGE_MIN_CYCLES
                                                             : pqt_pkg::LEAST_CYCLES;
  wire [31:0] lim_max_least = (ctrl.cond == pqt_pkg::COND_RANGE) ? pqt_pkg::RANGE_MAX_CYCLES
                                                                 : pqt_pkg::LEAST_CYCLES;
  wire [31:0] lim_min = (min_duration_limit < lim_least) ? lim_least
                      : (min_duration_limit > MOST_CYCLES) ? MOST_CYCLES
                      : min_duration_limit;
  wire [31:0] lim_max = (max_duration_limit < lim_max_least) ? lim_max_least
                      : (max_duration_limit > MOST_CYCLES) ? MOST_CYCLES
                      : max_duration_limit;

  // qualification of the pattern trigger
  wire longer_end = match_fall & (dur_cnt > lim_min);
  wire longer_timeout = match_now & match_prev & (dur_cnt == lim_min);
  wire shorter_end = match_fall & (dur_cnt < lim_max);
  wire range_end = match_fall & (dur_cnt > lim_min) & (dur_cnt < lim_max);
  logic pat_fire;
  always_comb begin
    case (ctrl.cond)
      pqt_pkg::COND_ENTERED: pat_fire = match_rise;
      pqt_pkg::COND_EXITED: pat_fire = match_fall;
      pqt_pkg::duration_longer_than: pat_fire = ctrl.fire_on_match_end ? longer_end
                                                                       : longer_timeout;
      pqt_pkg::duration_shorter_than: pat_fire = shorter_end;
      pqt_pkg::COND_RANGE: pat_fire = range_end;
      default: pat_fire = 1'b0;
    endcase
  end

  // serial pattern edge trigger
  wire src_lvl = lvl[ctrl.serial_pattern_input_select];
  wire src_prev = lvl_prev[ctrl.serial_pattern_input_select];
  wire src_rise = src_lvl & ~src_prev;
  wire src_fall = ~src_lvl & src_prev;
  logic [pqt_pkg::SYM_COUNT-1:0] sym_plus;
  logic [pqt_pkg::SYM_COUNT-1:0] sym_minus;
  genvar gs;
  generate
    for (gs = 0; gs < pqt_pkg::SYM_COUNT; gs++) begin : g_sym
      assign sym_plus[gs] = ser_pattern[2*gs +: 2] == pqt_pkg::SYM_PLUS;
      assign sym_minus[gs] = ser_pattern[2*gs +: 2] == pqt_pkg::SYM_MINUS;
    end
  endgenerate
  wire ser_valid = ctrl.serial_pattern_edge_sense ? |sym_plus : |sym_minus;
  wire ser_edge = ctrl.serial_pattern_edge_sense ? src_rise : src_fall;
  wire ser_fire = ser_edge & ser_valid;

  // bus decode
  wire wr = avs_write_in & ~avs_waitrequest_out;
  wire [31:0] be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                         {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  wire wr_ctrl = wr & (avs_address_in == pqt_pkg::OFS_CTRL);
  wire wr_crit = wr & (avs_address_in == pqt_pkg::OFS_CRIT);
  wire wr_min = wr & (avs_address_in == pqt_pkg::OFS_MIN_LIMIT);
  wire wr_max = wr & (avs_address_in == pqt_pkg::OFS_MAX_LIMIT);
  wire wr_pat = wr & (avs_address_in == pqt_pkg::OFS_SER_PATTERN);
  wire wr_clr = wr & (avs_address_in == pqt_pkg::OFS_IRQ_CLEAR);
  wire wr_en = wr & (avs_address_in == pqt_pkg::OFS_IRQ_ENABLE);
  wire [31:0] ctrl_word = {25'h0, ctrl[6:0]};
  wire [31:0] new_ctrl = (ctrl_word & ~be_mask) | (avs_writedata_in & be_mask);
  wire [31:0] new_crit = ({20'h0, crit} & ~be_mask) | (avs_writedata_in & be_mask);
  wire [31:0] new_min = (min_duration_limit & ~be_mask) | (avs_writedata_in & be_mask);
  wire [31:0] new_max = (max_duration_limit & ~be_mask) | (avs_writedata_in & be_mask);
  wire [31:0] new_pat = ({20'h0, ser_pattern} & ~be_mask) | (avs_writedata_in & be_mask);
  wire [31:0] clr_bits = avs_writedata_in & be_mask;
  wire [31:0] new_en = ({30'h0, irq_enable} & ~be_mask) | (avs_writedata_in & be_mask);
  wire [31:0] state_word = {26'h0, ser_valid, match_now, lvl};
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address_in)
      pqt_pkg::OFS_CTRL: rd_mux = ctrl_word;
      pqt_pkg::OFS_CRIT: rd_mux = {20'h0, crit};
      pqt_pkg::OFS_MIN_LIMIT: rd_mux = min_duration_limit;
      pqt_pkg::OFS_MAX_LIMIT: rd_mux = max_duration_limit;
      pqt_pkg::OFS_SER_PATTERN: rd_mux = {20'h0, ser_pattern};
      pqt_pkg::OFS_STATE: rd_mux = state_word;
      pqt_pkg::OFS_IRQ_STATUS: rd_mux = {30'h0, irq_status};
      pqt_pkg::OFS_IRQ_ENABLE: rd_mux = {30'h0, irq_enable};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  wire [pqt_pkg::IRQ_W-1:0] events = {ser_fire, pat_fire};
  // set wins over a clear in the same cycle
  wire [pqt_pkg::IRQ_W-1:0] next_status =
    (irq_status & ~(wr_clr ? clr_bits[pqt_pkg::IRQ_W-1:0] : 2'h0)) | events;
  wire [pqt_pkg::IRQ_W-1:0] next_enable = wr_en ? new_en[pqt_pkg::IRQ_W-1:0] : irq_enable;

  // bus slave: one wait cycle, then answer
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & avs_waitrequest_out);
      if (avs_read_in & avs_waitrequest_out) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl <= pqt_pkg::RST_CTRL;
      crit <= '0;
      min_duration_limit <= pqt_pkg::RST_MIN_LIMIT;
      max_duration_limit <= pqt_pkg::RST_MAX_LIMIT;
      ser_pattern <= pqt_pkg::RST_SER_PATTERN;
    end else if (ce_in) begin
      if (wr_ctrl) ctrl <= pqt_pkg::pqt_ctrl_t'({25'h0, new_ctrl[6:0]});
      if (wr_crit) crit <= new_crit[N*pqt_pkg::CRIT_W-1:0];
      if (wr_min) min_duration_limit <= new_min;
      if (wr_max) max_duration_limit <= new_max;
      if (wr_pat) ser_pattern <= new_pat[2*pqt_pkg::SYM_COUNT-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_status <= '0;
      irq_enable <= '0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_status <= next_status;
      irq_enable <= next_enable;
      irq_out <= |(next_status & next_enable);
    end
  end

  // duration counter and trigger outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lvl_prev <= '0;
      match_prev <= 1'b0;
      dur_cnt <= 32'h0000_0000;
      pattern_trigger_out <= 1'b0;
      serial_trigger_out <= 1'b0;
    end else if (ce_in) begin
      lvl_prev <= lvl;
      match_prev <= match_now;
      if (match_rise) begin
        dur_cnt <= 32'h0000_0001;
      end else if (match_now && dur_cnt != 32'hFFFF_FFFF) begin
        dur_cnt <= dur_cnt + 32'h0000_0001;
      end
      pattern_trigger_out <= pat_fire;
      serial_trigger_out <= ser_fire;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  property p_ser_rise;
    ce_in && ctrl.serial_pattern_edge_sense && ser_valid && src_rise |=> serial_trigger_out;
  endproperty
  a_ser_rise: assert property (p_ser_rise) else $error("no serial trigger on rise");

  property p_ser_fall;
    ce_in && !ctrl.serial_pattern_edge_sense && ser_valid && src_fall |=> serial_trigger_out;
  endproperty
  a_ser_fall: assert property (p_ser_fall) else $error("no serial trigger on fall");

  property p_ser_valid;
    ce_in && !ser_valid |=> !serial_trigger_out;
  endproperty
  a_ser_valid: assert property (p_ser_valid) else $error("trigger on invalid pattern");

  property p_sense_read;
    avs_read_in && avs_waitrequest_out && ce_in && avs_address_in == pqt_pkg::OFS_CTRL
      |=> !avs_waitrequest_out && avs_readdata_out[4] == $past(ctrl.serial_pattern_edge_sense);
  endproperty
  a_sense_read: assert property (p_sense_read) else $error("edge sense readback wrong");

  property p_high_crit;
    crit[2:0] == pqt_pkg::CRIT_HIGH && !lvl[0] |-> !match_now;
  endproperty
  a_high_crit: assert property (p_high_crit) else $error("low channel matched high");

  property p_ignore_all;
    crit == '0 |-> match_now;
  endproperty
  a_ignore_all: assert property (p_ignore_all) else $error("ignored channels broke match");

  property p_entered;
    ce_in && ctrl.cond == pqt_pkg::COND_ENTERED && match_rise |=> pattern_trigger_out;
  endproperty
  a_entered: assert property (p_entered) else $error("entered trigger missing");

  property p_exited;
    ce_in && ctrl.cond == pqt_pkg::COND_EXITED && match_fall |=> pattern_trigger_out;
  endproperty
  a_exited: assert property (p_exited) else $error("exited trigger missing");

  property p_longer;
    ce_in && ctrl.cond == pqt_pkg::duration_longer_than && ctrl.fire_on_match_end
      && match_fall && dur_cnt <= lim_min |=> !pattern_trigger_out;
  endproperty
  a_longer: assert property (p_longer) else $error("spurious longer trigger");

  property p_timeout;
    ce_in && ctrl.cond == pqt_pkg::duration_longer_than && !ctrl.fire_on_match_end
      && match_fall |=> !pattern_trigger_out;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout mode fired at end");

  property p_shorter;
    ce_in && ctrl.cond == pqt_pkg::duration_shorter_than && match_fall && dur_cnt < lim_max
      |=> pattern_trigger_out;
  endproperty
  a_shorter: assert property (p_shorter) else $error("shorter trigger missing");

  property p_range;
    ce_in && ctrl.cond == pqt_pkg::COND_RANGE && match_fall
      && (dur_cnt <= lim_min || dur_cnt >= lim_max) |=> !pattern_trigger_out;
  endproperty
  a_range: assert property (p_range) else $error("range trigger out of range");

  property p_restart;
    ce_in && match_rise |=> dur_cnt == 32'h0000_0001;
  endproperty
  a_restart: assert property (p_restart) else $error("counter did not restart");

  c_longer_timeout: cover property (ce_in && longer_timeout ##1 pattern_trigger_out);
  c_range_hit: cover property (ce_in && ctrl.cond == pqt_pkg::COND_RANGE ##1 pattern_trigger_out);
  c_serial: cover property (serial_trigger_out ##1 irq_out);
endmodule

// ==== pqt_probe_model.sv ====
// comparator-side model: one registered above-level bit per channel
// assumes the bench calls drive() from its own process; lag adds a cycle
module pqt_probe_model (
  input wire logic ref_clk_in,
  input wire logic lag_in,
  output logic [3:0] chan_above_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] level = 4'h0;
  logic [3:0] level_d = 4'h0;
  // slow comparator path, one level per channel for every trigger
  always @(posedge ref_clk_in) level_d <= level;
  assign chan_above_level_out = lag_in ? level_d : level;
  task automatic drive(input logic [3:0] v, input int hold);
    @(posedge ref_clk_in);
    level <= v;
    repeat (hold - 1) @(posedge ref_clk_in);
  endtask
endmodule

// ==== pqt_qualifier_tb.sv ====
// self-checking bench of the pattern trigger qualifier
// assumes the comparator model file; limits are given in clock cycles
module pqt_qualifier_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] A_CTRL = pqt_pkg::OFS_CTRL;
  localparam logic [5:0] A_CRIT = pqt_pkg::OFS_CRIT;
  localparam logic [5:0] A_SER = pqt_pkg::OFS_SER_PATTERN;
  localparam logic [5:0] A_ST = pqt_pkg::OFS_IRQ_STATUS;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic lag = 1'b0;
  logic ce = 1'b1;
  logic [3:0] chan;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wait_rq;
  logic pat_trig;
  logic ser_trig;
  logic irq;
  logic [31:0] got;
  logic [31:0] rnd = 32'h0000_4d15;
  logic [11:0] crit_tab [7] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h000, 12'h009, 12'h011};
  int exp_tab [7] = '{1, 1, 1, 1, 0, 0, 1};
  logic [31:0] ctrl_tab [4] = '{32'h0000_000a, 32'h0000_0002, 32'h0000_000b, 32'h0000_000c};
  int n_fail = 0;
  int samples_checked = 0;
  int n_pat = 0;
  int n_ser = 0;
  int base;
  int mn;
  int mx;
  int d;
  int e;
  always #50 ref_clk_in = ~ref_clk_in;
  pqt_qualifier #(.MOST_CYCLES(32'h0000_03e8)) i_pqt_qualifier (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce), .chan_above_level_in(chan),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq),
    .pattern_trigger_out(pat_trig), .serial_trigger_out(ser_trig), .irq_out(irq));
  pqt_probe_model i_pqt_probe_model (
    .ref_clk_in(ref_clk_in), .lag_in(lag), .chan_above_level_out(chan));
  always @(posedge ref_clk_in) begin
    if (pat_trig === 1'b1) n_pat <= n_pat + 1;
    if (ser_trig === 1'b1) n_ser <= n_ser + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic chk_cnt(input int g, input int x);
    samples_checked++;
    if (g != x) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask
  // one Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= v;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wait_rq !== 1'b0 && n < 40);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 40) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0000_0000);
    chk_val(got, x);
  endtask
  task automatic settle();
    repeat (8) @(posedge ref_clk_in);
  endtask
  task automatic pulse_seq();
    i_pqt_probe_model.drive(4'b0001, 5);
    i_pqt_probe_model.drive(4'b1001, 5);
    i_pqt_probe_model.drive(4'b0001, 5);
    i_pqt_probe_model.drive(4'b0000, 8);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd_chk(A_CTRL, 32'h0000_0018);
    rd_chk(A_CRIT, 32'h0000_0000);
    rd_chk(pqt_pkg::OFS_MIN_LIMIT, 32'h0000_0001);
    rd_chk(pqt_pkg::OFS_MAX_LIMIT, 32'h0000_0002);
    rd_chk(A_SER, 32'h0000_0001);
    bus(1'b1, 6'h3c, 32'hffff_ffff);
    rd_chk(6'h3c, 32'h0000_0000);
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 7; i++) begin
        bus(1'b1, A_CTRL, 32'(c));
        bus(1'b1, A_CRIT, {20'h0_0000, crit_tab[i]});
        settle();
        base = n_pat;
        pulse_seq();
        chk_cnt(n_pat - base, exp_tab[i]);
      end
    end
    i_pqt_probe_model.drive(4'b0101, 6);
    bus(1'b0, pqt_pkg::OFS_STATE, 32'h0000_0000);
    chk_val(got & 32'h0000_001f, 32'h0000_0015);
    i_pqt_probe_model.drive(4'b0000, 6);
    bus(1'b1, A_CRIT, 32'h0000_0001);
    for (int k = 0; k < 32; k++) begin
      rnd = xs(rnd);
      mn = 1 + int'(rnd[1:0]);
      mx = mn + 1 + int'(rnd[4:3]);
      d = 1 + int'(rnd[11:8]);
      lag <= rnd[12];
      e = (k % 4 < 2) ? int'(d > mn) : (k % 4 == 2) ? int'(d < mx) : int'(d > mn && d < mx);
      bus(1'b1, pqt_pkg::OFS_MIN_LIMIT, 32'(mn));
      bus(1'b1, pqt_pkg::OFS_MAX_LIMIT, 32'(mx));
      bus(1'b1, A_CTRL, ctrl_tab[k % 4]);
      settle();
      base = n_pat;
      i_pqt_probe_model.drive(4'b0001, d);
      if (d >= mn + 7) chk_cnt(n_pat - base, (k % 4 == 1) ? e : 0);
      i_pqt_probe_model.drive(4'b0000, 10);
      chk_cnt(n_pat - base, e);
    end
    bus(1'b1, A_CRIT, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      // sense matched to the lone symbol kind when i[3] equals !i[0]
      e = i[0] ? int'(!i[3]) : int'(i[3]);
      bus(1'b1, A_SER, i[3] ? 32'h0000_0003 : 32'h0000_0001);
      bus(1'b1, A_CTRL, 32'(i[2:1]) * 32 + 32'(i[0]) * 16 + 32'h0000_0008);
      rd_chk(A_CTRL, 32'(i[2:1]) * 32 + 32'(i[0]) * 16 + 32'h0000_0008);
      settle();
      base = n_ser;
      i_pqt_probe_model.drive(4'(1 << i[2:1]), 8);
      chk_cnt(n_ser - base, i[0] ? e : 0);
      i_pqt_probe_model.drive(4'b0000, 8);
      chk_cnt(n_ser - base, e);
      i_pqt_probe_model.drive(4'(1 << ((i[2:1] + 1) % 4)), 8);
      i_pqt_probe_model.drive(4'b0000, 8);
      chk_cnt(n_ser - base, e);
    end
    rd_chk(A_ST, 32'h0000_0003);
    bus(1'b1, A_SER, 32'h0000_0000);
    bus(1'b1, pqt_pkg::OFS_IRQ_CLEAR, 32'h0000_0003);
    rd_chk(A_ST, 32'h0000_0000);
    bus(1'b1, pqt_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
    bus(1'b1, A_CTRL, 32'h0000_0018);
    bus(1'b1, A_CRIT, 32'h0000_0001);
    pulse_seq();
    rd_chk(A_ST, 32'h0000_0001);
    chk_val({31'h0000_0000, irq}, 32'h0000_0001);
    bus(1'b1, pqt_pkg::OFS_IRQ_ENABLE, 32'h0000_0002);
    settle();
    chk_val({31'h0000_0000, irq}, 32'h0000_0000);
    bus(1'b1, pqt_pkg::OFS_IRQ_CLEAR, 32'h0000_0001);
    rd_chk(A_ST, 32'h0000_0000);
    rd_chk(pqt_pkg::OFS_IRQ_CLEAR, 32'h0000_0000);
    // frozen clock enable: a full pulse must leave no trigger behind
    base = n_pat;
    ce <= 1'b0;
    pulse_seq();
    chk_cnt(n_pat - base, 0);
    ce <= 1'b1;
    settle();
    chk_cnt(n_pat - base, 0);
    end_of_test();
  end
endmodule
